/* core/nvs_ctrl.sv */
/*
  Nested interrupt state logic: per-line pending/active state, priorities,
  priority selection and an AHB-Lite register slave.
  Assumes the processor pulses svc_enter/svc_return for one cycle and handles
  stacking itself; interrupt lines come from other clock domains or pins.
*/
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module nvs_ctrl #(
  parameter int NUM = nvs_pkg::NUM_IRQ
) (
  input wire logic clk, // Processor clock
  input wire logic rst_b, // Async reset, active low
  input wire logic ce, // Clock enable; freezes state when low
  input wire nvs_pkg::nvs_ahb_req_t ahb_req, // AHB-Lite request signals
  output nvs_pkg::nvs_ahb_rsp_t ahb_rsp, // AHB-Lite response signals
  input wire logic [NUM-1:0] irq_in, // Peripheral interrupt lines
  input wire logic nmi_in, // External non-maskable interrupt line
  input wire logic svc_enter, // Pulse: core takes the presented request
  input wire logic [4:0] svc_enter_id, // Line number being entered
  input wire logic svc_return, // Pulse: core returns from a service routine
  input wire logic [4:0] svc_return_id, // Line number being returned from
  output nvs_pkg::nvs_req_t irq_req, // Highest-urgency pending request
  output logic nmi_req, // Non-maskable request level
  output logic stack_req, // Pulse: stack state on entry
  output logic unstack_req, // Pulse: unstack state on exit
  output logic irq_out // Level: unmasked event status set
);

  // Two-flop synchronisers for lines from outside the clock domain
  logic [NUM-1:0] irq_s1_r, irq_s2_r, irq_prev_r;
  logic nmi_s1_r, nmi_s2_r, nmi_prev_r;

  // Control and state registers
  logic [NUM-1:0] enable_r, pulse_r, pend_r, act_r;
  logic [2:0] grouping_r;
  logic [nvs_pkg::PRIO_W-1:0] prio_r [NUM];
  logic [nvs_pkg::EV_W-1:0] ev_stat_r, ev_mask_r;
  logic nmi_lat_r;
  logic stack_r, unstack_r;
  nvs_pkg::nvs_req_t req_r;

  // AHB data-phase capture
  logic dp_wr_r;
  logic [7:0] dp_addr_r;
  logic [31:0] rdata_r;

  wire logic addr_phase = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
  wire logic wr_now = dp_wr_r;
  wire logic [31:0] wd = ahb_req.hwdata;
  wire logic wr_set = wr_now && (dp_addr_r == nvs_pkg::OFS_SET_PEND);
  wire logic wr_clr = wr_now && (dp_addr_r == nvs_pkg::OFS_CLR_PEND);
  wire logic wr_trig = wr_now && (dp_addr_r == nvs_pkg::OFS_TRIGGER);
  wire logic wr_en = wr_now && (dp_addr_r == nvs_pkg::OFS_ENABLE);
  wire logic wr_pm = wr_now && (dp_addr_r == nvs_pkg::OFS_PULSE_MODE);
  wire logic wr_grp = wr_now && (dp_addr_r == nvs_pkg::OFS_GROUPING);
  wire logic wr_ist = wr_now && (dp_addr_r == nvs_pkg::OFS_INT_STAT);
  wire logic wr_imsk = wr_now && (dp_addr_r == nvs_pkg::OFS_INT_MASK);
  wire logic wr_prio = wr_now && (dp_addr_r >= nvs_pkg::OFS_PRIO0) && (dp_addr_r < nvs_pkg::OFS_PRIO_END);
  wire logic [7:0] prio_rel = dp_addr_r - nvs_pkg::OFS_PRIO0;
  wire logic [3:0] prio_word = prio_rel[5:2];

  wire logic [NUM-1:0] rise = irq_s2_r & ~irq_prev_r;
  wire logic [NUM-1:0] trig_hot = wr_trig ? (NUM'(1) << wd[4:0]) : '0;
  wire logic [NUM-1:0] set_sw = (wr_set ? wd[NUM-1:0] : '0) | trig_hot;
  wire logic [NUM-1:0] clr_sw = wr_clr ? wd[NUM-1:0] : '0;
  wire logic [NUM-1:0] ent_hot = svc_enter ? (NUM'(1) << svc_enter_id) : '0;
  wire logic [NUM-1:0] ret_hot = svc_return ? (NUM'(1) << svc_return_id) : '0;

  logic [NUM-1:0] pend_nxt, act_nxt;
  logic [NUM-1:0] new_pend;

  // Per-line state update
  for (genvar i = 0; i < NUM; i++) begin : g_line
    // A high level line re-pends only while idle; entry in the same cycle wins
    wire logic lvl_hold = irq_s2_r[i] && !act_r[i] && !ent_hot[i];
    wire logic prio_hit = wr_prio && (prio_word == 4'(i / nvs_pkg::PRIO_PER_WORD));
    always_comb begin
      pend_nxt[i] = pend_r[i];
      act_nxt[i] = act_r[i];
      if (pulse_r[i]) begin
        if (rise[i] || set_sw[i]) begin
          pend_nxt[i] = 1'b1;
        end else if (clr_sw[i]) begin
          pend_nxt[i] = 1'b0;
        end else if (ent_hot[i]) begin
          pend_nxt[i] = 1'b0;
        end
        if (ent_hot[i]) begin
          act_nxt[i] = 1'b1;
        end else if (ret_hot[i]) begin
          act_nxt[i] = 1'b0;
        end
      end else begin
        if (lvl_hold || rise[i] || set_sw[i]) begin
          pend_nxt[i] = 1'b1;
        end else if (clr_sw[i] && !irq_s2_r[i]) begin
          pend_nxt[i] = 1'b0;
        end else if (ent_hot[i]) begin
          pend_nxt[i] = 1'b0;
        end
        if (ent_hot[i]) begin
          act_nxt[i] = 1'b1;
        end else if (ret_hot[i]) begin
          act_nxt[i] = 1'b0;
          pend_nxt[i] = irq_s2_r[i] | set_sw[i];
        end
      end
      new_pend[i] = pend_nxt[i] & ~pend_r[i];
    end

    // Priorities may be rewritten at run time; the next selection uses them at once
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        prio_r[i] <= '0;
      end else if (ce && prio_hit) begin
        prio_r[i] <= wd[(i % nvs_pkg::PRIO_PER_WORD) * 8 + nvs_pkg::PRIO_LSB +: nvs_pkg::PRIO_W];
      end
    end
  end

  // Priority selection: strict less-than keeps the lowest number on ties
  // Active lines drop out here; preemption between nesting levels is the core's call
  logic sel_valid;
  logic [nvs_pkg::ID_W-1:0] sel_id;
  logic [nvs_pkg::PRIO_W-1:0] sel_prio;
  always_comb begin
    sel_valid = 1'b0;
    sel_id = '0;
    sel_prio = '1;
    for (int k = 0; k < NUM; k++) begin
      if (pend_r[k] && enable_r[k] && !act_r[k] && (!sel_valid || prio_r[k] < sel_prio)) begin
        sel_valid = 1'b1;
        sel_id = nvs_pkg::ID_W'(k);
        sel_prio = prio_r[k];
      end
    end
  end

  // Group part: bits above the grouping split; subpriority bits are masked off
  wire logic [nvs_pkg::PRIO_W-1:0] grp_mask = nvs_pkg::PRIO_W'(3'h7 << grouping_r);
  wire logic [nvs_pkg::PRIO_W-1:0] sel_group = sel_prio & grp_mask;

  // Events: new pending line, NMI edge; sticky until software writes ones
  wire logic nmi_rise = nmi_s2_r & ~nmi_prev_r;
  wire logic any_new_pend = |new_pend;
  wire logic [nvs_pkg::EV_W-1:0] ev_set = {nmi_rise, any_new_pend};
  wire logic [nvs_pkg::EV_W-1:0] ev_clr = wr_ist ? wd[nvs_pkg::EV_W-1:0] : '0;

  // Synchronisers; only the second stage is read by any logic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_s1_r <= '0;
    end else if (ce) begin
      irq_s1_r <= irq_in;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_s2_r <= '0;
    end else if (ce) begin
      irq_s2_r <= irq_s1_r;
    end
  end

  // Edge history resets to the idle low level, so no false edge follows reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_prev_r <= '0;
    end else if (ce) begin
      irq_prev_r <= irq_s2_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_s1_r <= 1'b0;
    end else if (ce) begin
      nmi_s1_r <= nmi_in;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_s2_r <= 1'b0;
    end else if (ce) begin
      nmi_s2_r <= nmi_s1_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_prev_r <= 1'b0;
    end else if (ce) begin
      nmi_prev_r <= nmi_s2_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= '0;
    end else if (ce) begin
      pend_r <= pend_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_r <= '0;
    end else if (ce) begin
      act_r <= act_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_r <= '0;
    end else if (ce) begin
      req_r <= '{valid: sel_valid, id: sel_id, prio: sel_prio, group: sel_group};
    end
  end

  // NMI held until the core enters its handler; not maskable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_lat_r <= 1'b0;
    end else if (ce) begin
      nmi_lat_r <= nmi_rise | (nmi_lat_r & ~svc_enter);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stack_r <= 1'b0;
    end else if (ce) begin
      stack_r <= svc_enter;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unstack_r <= 1'b0;
    end else if (ce) begin
      unstack_r <= svc_return;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_r <= NUM'(nvs_pkg::RST_ENABLE);
    end else if (ce && wr_en) begin
      enable_r <= wd[NUM-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_r <= NUM'(nvs_pkg::RST_PULSE);
    end else if (ce && wr_pm) begin
      pulse_r <= wd[NUM-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      grouping_r <= nvs_pkg::RST_GROUPING;
    end else if (ce && wr_grp) begin
      grouping_r <= wd[2:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_mask_r <= '0;
    end else if (ce && wr_imsk) begin
      ev_mask_r <= wd[nvs_pkg::EV_W-1:0];
    end
  end

  // Set beats write-one-to-clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_stat_r <= '0;
    end else if (ce) begin
      ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  wire logic [31:0] st_id = 32'(req_r.id) << nvs_pkg::ST_ID_LSB;
  wire logic [31:0] st_valid = 32'(req_r.valid) << nvs_pkg::ST_VALID_BIT;
  wire logic [31:0] st_nmi = 32'(nmi_lat_r) << nvs_pkg::ST_NMI_BIT;
  wire logic [31:0] st_prio = 32'(req_r.prio) << nvs_pkg::ST_PRIO_LSB;
  wire logic [31:0] status_word = st_id | st_valid | st_nmi | st_prio;
  // Only the low address byte is decoded, so the register set repeats across the window
  wire logic [7:0] a_addr = ahb_req.haddr[7:0];
  wire logic [7:0] a_rel = a_addr - nvs_pkg::OFS_PRIO0;
  wire logic a_is_prio = (a_addr >= nvs_pkg::OFS_PRIO0) && (a_addr < nvs_pkg::OFS_PRIO_END);

  logic [31:0] prio_word_rd;
  always_comb begin
    prio_word_rd = '0;
    for (int k = 0; k < NUM; k++) begin
      if (a_rel[5:2] == 4'(k / nvs_pkg::PRIO_PER_WORD)) begin
        prio_word_rd[(k % nvs_pkg::PRIO_PER_WORD) * 8 + nvs_pkg::PRIO_LSB +: nvs_pkg::PRIO_W] = prio_r[k];
      end
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    if (a_addr == nvs_pkg::OFS_ENABLE) begin
      rd_mux = 32'(enable_r);
    end else if (a_addr == nvs_pkg::OFS_SET_PEND || a_addr == nvs_pkg::OFS_CLR_PEND) begin
      rd_mux = 32'(pend_r);
    end else if (a_addr == nvs_pkg::OFS_ACTIVE) begin
      rd_mux = 32'(act_r);
    end else if (a_addr == nvs_pkg::OFS_PULSE_MODE) begin
      rd_mux = 32'(pulse_r);
    end else if (a_addr == nvs_pkg::OFS_GROUPING) begin
      rd_mux = 32'(grouping_r);
    end else if (a_addr == nvs_pkg::OFS_STATUS) begin
      rd_mux = status_word;
    end else if (a_addr == nvs_pkg::OFS_INT_STAT) begin
      rd_mux = 32'(ev_stat_r);
    end else if (a_addr == nvs_pkg::OFS_INT_MASK) begin
      rd_mux = 32'(ev_mask_r);
    end else if (a_is_prio) begin
      rd_mux = prio_word_rd;
    end else begin
      rd_mux = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dp_wr_r <= 1'b0;
    end else if (ce) begin
      dp_wr_r <= addr_phase && ahb_req.hwrite;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dp_addr_r <= '0;
    end else if (ce && addr_phase) begin
      dp_addr_r <= a_addr;
    end
  end

  // Read data is taken in the address phase; a read right behind a write to it sees the old value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= '0;
    end else if (ce && addr_phase && !ahb_req.hwrite) begin
      rdata_r <= rd_mux;
    end
  end

  // Zero wait states and OKAY only: every access completes in its data phase
  wire logic rsp_ready = 1'b1;
  wire logic rsp_err = 1'b0;
  assign ahb_rsp = '{hreadyout: rsp_ready, hresp: rsp_err, hrdata: rdata_r};
  assign irq_req = req_r;
  assign nmi_req = nmi_lat_r;
  assign stack_req = stack_r;
  assign unstack_req = unstack_r;
  wire logic [nvs_pkg::EV_W-1:0] ev_live = ev_stat_r & ev_mask_r;
  assign irq_out = |ev_live;

endmodule // nvs_ctrl

/* core/nvs_pkg.sv */
/*
  Package for the nested interrupt state logic: register offsets, field layouts,
  reset values, state encoding and bus carriers.
  Assumes a single AHB-Lite master with 32-bit single word transfers.
*/
// What this block does
// - Twenty-two peripheral interrupt inputs, each with its own priority 0 to 7.
// - Lower priority number means more urgent; zero is the most urgent.
// - Priority splits into group and subpriority; priorities change at run time.
// - One external non-maskable interrupt input besides the maskable lines.
// - Pulse inputs are sampled on each rising clock edge and latched.
// - Level input sampled high while not active makes the interrupt pending.
// - A rising edge on the input makes the interrupt pending.
// - Set-pending bit write or trigger register write makes the interrupt pending.
// - Service entry clears pending and moves the interrupt to active.
// - Level interrupt return samples input: pending if high, else inactive.
// - Pulse during service gives active-and-pending, then pending on return.
// - No pulse during service: pulse interrupt returns to inactive.
// - Clear-pending on level interrupt: no change if input high, else inactive.
// - Clear-pending on pulse: pending to inactive, active-and-pending to active.
// - Entry and exit stack and unstack processor state without instructions.
package nvs_pkg;

  localparam int NUM_IRQ = 22;
  localparam int PRIO_W = 3;
  localparam int ID_W = 5;

  // Register byte offsets
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_SET_PEND = 8'h04;
  localparam logic [7:0] OFS_CLR_PEND = 8'h08;
  localparam logic [7:0] OFS_ACTIVE = 8'h0C;
  localparam logic [7:0] OFS_PULSE_MODE = 8'h10;
  localparam logic [7:0] OFS_TRIGGER = 8'h14;
  localparam logic [7:0] OFS_GROUPING = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_INT_STAT = 8'h20;
  localparam logic [7:0] OFS_INT_MASK = 8'h24;
  localparam logic [7:0] OFS_PRIO0 = 8'h40;
  localparam logic [7:0] OFS_PRIO_END = 8'h58;

  // Priority bytes: 4 per word, priority in the top three bits of each byte
  localparam int PRIO_LSB = 5;
  localparam int PRIO_PER_WORD = 4;

  // Status register fields
  localparam int ST_ID_LSB = 0;
  localparam int ST_VALID_BIT = 8;
  localparam int ST_NMI_BIT = 9;
  localparam int ST_PRIO_LSB = 12;

  // Event bits for the sticky event register
  localparam int EV_PEND_NEW = 0;
  localparam int EV_NMI = 1;
  localparam int EV_W = 2;

  localparam logic [NUM_IRQ-1:0] RST_ENABLE = 22'h000000;
  localparam logic [NUM_IRQ-1:0] RST_PULSE = 22'h000000;
  localparam logic [2:0] RST_GROUPING = 3'h0;

  typedef enum logic [1:0] {
    NVS_INACTIVE,
    NVS_PENDING,
    NVS_ACTIVE,
    NVS_ACT_PEND
  } nvs_state_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } nvs_ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } nvs_ahb_rsp_t;

  typedef struct packed {
    logic valid;
    logic [ID_W-1:0] id;
    logic [PRIO_W-1:0] prio;
    logic [PRIO_W-1:0] group;
  } nvs_req_t;

endpackage

/* verif/nvs_core_model.sv */
/*
  Model of the peripheral sources and the processor core facing nvs_ctrl.
  Assumes it is driven by the bench through its tasks, on clk rising edges.
*/
`timescale 1ns/1ps
module nvs_core_model (
  input wire logic clk, // Clock
  output logic [nvs_pkg::NUM_IRQ-1:0] irq_in = '0, // Lines
  output logic nmi_in = 1'b0, // NMI line
  output logic svc_enter = 1'b0, // Entry pulse
  output logic [4:0] svc_enter_id = 5'h1F, // Entry id
  output logic svc_return = 1'b0, // Return pulse
  output logic [4:0] svc_return_id = 5'h1F // Return id
);
  // One full cycle is the shortest pulse a source may give
  task automatic pulse(input int n);
    @(posedge clk);
    irq_in[n] <= 1'b1;
    @(posedge clk);
    irq_in[n] <= 1'b0;
  endtask
  task automatic level(input int n, input logic v);
    @(posedge clk);
    irq_in[n] <= v;
  endtask
  task automatic nmi();
    @(posedge clk);
    nmi_in <= 1'b1;
    @(posedge clk);
    nmi_in <= 1'b0;
  endtask
  // Ids are inverted once the pulse is gone so the stale id left by lines 0 to 9 never looks valid
  task automatic svc(input logic ret, input logic [4:0] id);
    @(posedge clk);
    svc_enter <= !ret;
    svc_return <= ret;
    svc_enter_id <= id;
    svc_return_id <= id;
    @(posedge clk);
    svc_enter <= 1'b0;
    svc_return <= 1'b0;
    svc_enter_id <= ~id;
    svc_return_id <= ~id;
    repeat (3) @(posedge clk);
  endtask
endmodule // nvs_core_model

/* verif/nvs_ctrl_monitor.sv */
/*
  Port checker for nvs_ctrl, bound to every instance.
  Assumes one clock clk and asynchronous active-low rst_b.
*/
`timescale 1ns/1ps
module nvs_ctrl_monitor #(
  parameter int NUM = nvs_pkg::NUM_IRQ
) (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic ce, // Enable
  input wire nvs_pkg::nvs_ahb_req_t ahb_req, // Bus in
  input wire nvs_pkg::nvs_ahb_rsp_t ahb_rsp, // Bus out
  input wire logic [NUM-1:0] irq_in, // Lines
  input wire logic nmi_in, // NMI line
  input wire logic svc_enter, // Entry
  input wire logic [4:0] svc_enter_id, // Entry id
  input wire logic svc_return, // Return
  input wire logic [4:0] svc_return_id, // Return id
  input wire nvs_pkg::nvs_req_t irq_req, // Request
  input wire logic nmi_req, // NMI request
  input wire logic stack_req, // Stack
  input wire logic unstack_req, // Unstack
  input wire logic irq_out // Event irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  chk_stack_entry: assert property (svc_enter && ce |=> stack_req)
    else $error("no stack pulse after entry");
  chk_stack_cause: assert property (stack_req |-> $past(svc_enter && ce))
    else $error("stack pulse without entry");
  chk_unstack_exit: assert property (svc_return && ce |=> unstack_req ##1 !unstack_req)
    else $error("unstack pulse wrong");
  chk_req_id_range: assert property (irq_req.valid |-> irq_req.id < NUM)
    else $error("request id out of range");
  chk_group_bits: assert property (irq_req.valid |-> (irq_req.group & ~irq_req.prio) == 3'h0)
    else $error("group not a prefix of priority");
  chk_entry_clears: assert property (svc_enter && ce |=> ##1 !(irq_req.valid && irq_req.id == $past(svc_enter_id, 2)))
    else $error("entered line still requested");
  chk_nmi_latch: assert property ($rose(nmi_in) |-> ##[1:4] nmi_req)
    else $error("nmi edge not latched");
  chk_nmi_clear: assert property (nmi_req && svc_enter && ce && !nmi_in |=> !nmi_req)
    else $error("nmi request not cleared by entry");
endmodule // nvs_ctrl_monitor
bind nvs_ctrl nvs_ctrl_monitor #(.NUM(NUM)) u_mon (.clk(clk), .rst_b(rst_b), .ce(ce),
  .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .irq_in(irq_in), .nmi_in(nmi_in), .svc_enter(svc_enter),
  .svc_enter_id(svc_enter_id), .svc_return(svc_return), .svc_return_id(svc_return_id),
  .irq_req(irq_req), .nmi_req(nmi_req), .stack_req(stack_req), .unstack_req(unstack_req), .irq_out(irq_out));

/* verif/nvs_ctrl_tb.sv */
/*
  Self-checking bench for nvs_ctrl: AHB-Lite register tasks plus core model.
  Assumes the zero-wait slave and line timing given by the designer.
*/
`timescale 1ns/1ps
module nvs_ctrl_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  nvs_pkg::nvs_ahb_req_t req = '0;
  nvs_pkg::nvs_ahb_rsp_t rsp;
  nvs_pkg::nvs_req_t irq_req;
  wire logic [21:0] irq_in;
  wire logic nmi_in, sve, svr;
  wire logic [4:0] sve_id, svr_id;
  logic nmi_req, stack_req, unstack_req, irq_out;
  logic [31:0] q;
  int bad_count = 0;
  int compares = 0;
  always #2.5 clk = ~clk;
  nvs_pkg::nvs_ahb_req_t bus;
  always_comb begin
    bus = req;
    bus.hready = rsp.hreadyout;
  end
  nvs_core_model core (.clk(clk), .irq_in(irq_in), .nmi_in(nmi_in), .svc_enter(sve),
    .svc_enter_id(sve_id), .svc_return(svr), .svc_return_id(svr_id));
  nvs_ctrl dut (.clk(clk), .rst_b(rst_b), .ce(ce), .ahb_req(bus), .ahb_rsp(rsp), .irq_in(irq_in),
    .nmi_in(nmi_in), .svc_enter(sve), .svc_enter_id(sve_id), .svc_return(svr), .svc_return_id(svr_id),
    .irq_req(irq_req), .nmi_req(nmi_req), .stack_req(stack_req), .unstack_req(unstack_req), .irq_out(irq_out));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    req.hsel <= 1'b1;
    req.haddr <= {24'h000000, a};
    req.htrans <= 2'h2;
    req.hwrite <= w;
    req.hsize <= 3'h2;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    req.hsel <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= d;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    q = rsp.hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
    // The write lands on the edge that ends the task; let it settle before outputs are sampled
    cyc(1);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  task automatic rq(input logic [4:0] id, input logic [2:0] p);
    cyc(3);
    chk({23'h0, irq_req.valid, irq_req.id, irq_req.prio}, {23'h0, 1'b1, id, p});
  endtask
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    stop_test();
  end
  initial begin
    cyc(10);
    rst_b <= 1'b1;
    rc(nvs_pkg::OFS_ENABLE, 32'h0);
    rc(8'h30, 32'h0);
    wr(nvs_pkg::OFS_PRIO0, 32'hA0000000);
    wr(nvs_pkg::OFS_PRIO0 + 8'h04, 32'h40000000);
    wr(nvs_pkg::OFS_PRIO0 + 8'h08, 32'h00004000);
    wr(nvs_pkg::OFS_ENABLE, 32'h003FFFFF);
    wr(nvs_pkg::OFS_SET_PEND, 32'h00000288);
    rc(nvs_pkg::OFS_SET_PEND, 32'h00000288);
    rq(5'h07, 3'h2);
    core.svc(1'b0, 5'h07);
    rc(nvs_pkg::OFS_ACTIVE, 32'h00000080);
    rc(nvs_pkg::OFS_SET_PEND, 32'h00000208);
    rq(5'h09, 3'h2);
    core.svc(1'b1, 5'h07);
    rc(nvs_pkg::OFS_ACTIVE, 32'h0);
    wr(nvs_pkg::OFS_CLR_PEND, 32'h00000208);
    rc(nvs_pkg::OFS_SET_PEND, 32'h0);
    wr(nvs_pkg::OFS_TRIGGER, 32'h00000005);
    rc(nvs_pkg::OFS_SET_PEND, 32'h00000020);
    wr(nvs_pkg::OFS_CLR_PEND, 32'h00000020);
    wr(nvs_pkg::OFS_INT_MASK, 32'h1);
    chk({31'h0, irq_out}, 32'h1);
    wr(nvs_pkg::OFS_INT_STAT, 32'h3);
    chk({31'h0, irq_out}, 32'h0);
    core.nmi();
    cyc(5);
    chk({31'h0, nmi_req}, 32'h1);
    rc(nvs_pkg::OFS_INT_STAT, 32'h2);
    chk({31'h0, irq_out}, 32'h0);
    wr(nvs_pkg::OFS_INT_MASK, 32'h3);
    chk({31'h0, irq_out}, 32'h1);
    core.level(2, 1'b1);
    cyc(5);
    rc(nvs_pkg::OFS_SET_PEND, 32'h4);
    wr(nvs_pkg::OFS_CLR_PEND, 32'h4);
    rc(nvs_pkg::OFS_SET_PEND, 32'h4);
    core.svc(1'b0, 5'h02);
    chk({31'h0, nmi_req}, 32'h0);
    rc(nvs_pkg::OFS_SET_PEND, 32'h0);
    rc(nvs_pkg::OFS_ACTIVE, 32'h4);
    core.svc(1'b1, 5'h02);
    rc(nvs_pkg::OFS_SET_PEND, 32'h4);
    core.level(2, 1'b0);
    cyc(5);
    wr(nvs_pkg::OFS_CLR_PEND, 32'h4);
    rc(nvs_pkg::OFS_SET_PEND, 32'h0);
    wr(nvs_pkg::OFS_PULSE_MODE, 32'h10);
    core.pulse(4);
    cyc(5);
    rc(nvs_pkg::OFS_SET_PEND, 32'h10);
    core.svc(1'b0, 5'h04);
    core.pulse(4);
    cyc(5);
    rc(nvs_pkg::OFS_SET_PEND, 32'h10);
    rc(nvs_pkg::OFS_ACTIVE, 32'h10);
    wr(nvs_pkg::OFS_CLR_PEND, 32'h10);
    rc(nvs_pkg::OFS_SET_PEND, 32'h0);
    rc(nvs_pkg::OFS_ACTIVE, 32'h10);
    core.pulse(4);
    cyc(5);
    core.svc(1'b1, 5'h04);
    rc(nvs_pkg::OFS_SET_PEND, 32'h10);
    rc(nvs_pkg::OFS_ACTIVE, 32'h0);
    core.svc(1'b0, 5'h04);
    core.svc(1'b1, 5'h04);
    rc(nvs_pkg::OFS_SET_PEND, 32'h0);
    core.pulse(4);
    cyc(5);
    wr(nvs_pkg::OFS_CLR_PEND, 32'h10);
    rc(nvs_pkg::OFS_SET_PEND, 32'h0);
    wr(nvs_pkg::OFS_SET_PEND, 32'h8);
    wr(nvs_pkg::OFS_GROUPING, 32'h2);
    rq(5'h03, 3'h5);
    chk({29'h0, irq_req.group}, 32'h4);
    wr(nvs_pkg::OFS_PRIO0, 32'h20000000);
    rq(5'h03, 3'h1);
    chk({29'h0, irq_req.group}, 32'h0);
    stop_test();
  end
endmodule // nvs_ctrl_tb
